// file: plm_defs.svh
/*
 Register offsets, field positions, reset values and detector thresholds
 of the potential-loss supervision block.
 Assumes byte addresses on an 8-bit register address port, one word each.
*/
`ifndef PLM_DEFS_SVH
`define PLM_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define PLM_OFS_MODE      8'h00
`define PLM_OFS_STATUS    8'h04
`define PLM_OFS_IRQ_STAT  8'h08
`define PLM_OFS_IRQ_MASK  8'h0C
`define PLM_OFS_PICKUP    8'h10
`define PLM_OFS_MASK_BASE 8'h20
`define PLM_NUM_MASKS     10

// ----------------------------------------------------------------------
// Mode codes as software writes them
// ----------------------------------------------------------------------
`define PLM_CODE_N 3'h0
`define PLM_CODE_Y 3'h1
`define PLM_CODE_1 3'h2
`define PLM_CODE_2 3'h3
`define PLM_CODE_3 3'h4
`define PLM_CODE_4 3'h5

// ----------------------------------------------------------------------
// Fields, reset values, thresholds (mV and mA secondary)
// ----------------------------------------------------------------------
`define PLM_IRQ_COND      0
`define PLM_IRQ_FLAG      1
`define PLM_IRQ_ALARM     2
`define PLM_FLAG_POS      16
`define PLM_RST_PICKUP    16'h0000
`define PLM_V2_PICKUP_MV  16'd14000
`define PLM_I2_ABSENT_MA  16'd83
`define PLM_V1_PICKUP_MV  16'd14000

`endif

// file: plm_pkg.sv
/*
 Types shared by the potential-loss supervision block.
 Assumes nothing of its surroundings.
*/
`default_nettype none

package plm_pkg;

    // ------------------------------------------------------------------
    // Supervision mode and detector bundle
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {MODE_N, MODE_Y, MODE_1, MODE_2, MODE_3, MODE_4} plm_mode_type;

    typedef struct packed {
        logic neg_v;
        logic neg_i;
        logic pos_v;
        logic phase_oc;
    } plm_det_type;

endpackage

`default_nettype wire

// file: plm_supervision.sv
/*
 Potential-loss detection and supervision with ten programmable logic masks,
 a small register port and a sticky interrupt.
 Assumes all inputs are synchronous to clk, one clk edge per processing
 interval, and sequence magnitudes in mV and mA secondary.
*/
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

// Behaviour
// [R1] Flag loss when negative-sequence voltage present without negative-sequence current.
// [R2] Also flag loss when positive-sequence voltage and phase overcurrent both absent.
// [R3] V2 detector picks up above 14 V; I2 absent below 0.083 A.
// [R4] Total loss when V1 below 14 V and no phase overcurrent.
// [R5] Mode accepts only N, Y, 1, 2, 3, 4; other writes ignored.
// [R6] Modes Y, 1, 2, 3 block distance and force directional forward.
// [R7] Modes N and 4 leave distance and directional elements unblocked.
// [R8] Modes 1 and 3 gate the flag with breaker closed input.
// [R9] Modes 2, 3, 4 close alarm on loss; N, Y, 1 never do.
// [R10] In mode 3 the alarm follows the breaker-gated flag.
// [R11] The flag is a selectable bit of every programmable mask.
// [R12] Ten masks: four trip, four output contacts, reclose initiate and cancel.
// [R13] Phase overcurrent bit is OR of three phases against one pickup.
// [R14] Outputs re-evaluated each interval, drop out once no term holds.
module plm_supervision
    import plm_pkg::*;
#(
    parameter int RW_W = 24
)(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Measured quantities
    input  wire logic [15:0]       v2_mag,
    input  wire logic [15:0]       i2_mag,
    input  wire logic [15:0]       v1_mag,
    input  wire logic [15:0]       phase_i_a,
    input  wire logic [15:0]       phase_i_b,
    input  wire logic [15:0]       phase_i_c,
    // Discrete inputs
    input  wire logic              breaker_closed_input,
    input  wire logic              permissive_trip_in,
    input  wire logic              block_trip_in,
    input  wire logic              breaker_open_timer_in,
    input  wire logic [RW_W-1:0]   relay_word_in,
    // Outputs
    output logic                   potential_loss_flag,
    output logic                   distance_block,
    output logic                   directional_forward,
    output logic                   alarm_contact,
    output logic                   trip_contact,
    output logic [9:0]             mask_hit,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (RW_W <= `PLM_FLAG_POS || RW_W > 32)
        begin : g_bad_width
            $error("RW_W must exceed the flag position and fit in 32 bits");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    plm_mode_type    mode_ff;
    plm_det_type     det_ff;
    logic [15:0]     pickup_ff;
    logic [RW_W-1:0] mask_ff [`PLM_NUM_MASKS];
    logic [2:0]      irq_stat_ff;
    logic [2:0]      irq_mask_ff;
    logic [31:0]     rdata_ff;
    logic            cond_ff;
    logic            flag_ff;
    logic            block_ff;
    logic            alarm_ff;
    logic            trip_ff;
    logic            irq_ff;
    logic [9:0]      hit_ff;

    logic            nxt_cond;
    logic            nxt_flag;
    logic            nxt_block;
    logic            nxt_alarm;
    logic [RW_W-1:0] relay_word;
    logic [7:0]      mask_ofs;
    logic [3:0]      mask_idx;
    logic            mask_sel;
    logic [2:0]      irq_evt;

    assign mask_ofs = reg_addr - `PLM_OFS_MASK_BASE;
    assign mask_idx = mask_ofs[5:2];
    assign mask_sel = (reg_addr >= `PLM_OFS_MASK_BASE) && (mask_ofs[1:0] == 2'b00)
                      && (mask_ofs[7:6] == 2'b00) && (mask_idx < 4'(`PLM_NUM_MASKS));

    function automatic logic [2:0] mode_code(input plm_mode_type m);
        logic [2:0] c;
        c = `PLM_CODE_N;
        case (m)
            MODE_Y:  c = `PLM_CODE_Y;
            MODE_1:  c = `PLM_CODE_1;
            MODE_2:  c = `PLM_CODE_2;
            MODE_3:  c = `PLM_CODE_3;
            MODE_4:  c = `PLM_CODE_4;
            default: c = `PLM_CODE_N;
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------
    // Unknown mode codes are dropped so the mode never leaves the legal set.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            mode_ff <= MODE_N;
        else if (reg_wr && reg_addr == `PLM_OFS_MODE)
        begin
            case (reg_wdata[2:0])                              // R5
                `PLM_CODE_N: mode_ff <= MODE_N;
                `PLM_CODE_Y: mode_ff <= MODE_Y;
                `PLM_CODE_1: mode_ff <= MODE_1;
                `PLM_CODE_2: mode_ff <= MODE_2;
                `PLM_CODE_3: mode_ff <= MODE_3;
                `PLM_CODE_4: mode_ff <= MODE_4;
                default:     mode_ff <= mode_ff;
            endcase
        end
    end

    // Pickup setting and the ten logic masks.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pickup_ff <= `PLM_RST_PICKUP;
            for (int i = 0; i < `PLM_NUM_MASKS; i++)
                mask_ff[i] <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `PLM_OFS_PICKUP)
                pickup_ff <= reg_wdata[15:0];
            if (mask_sel)
                mask_ff[mask_idx] <= reg_wdata[RW_W-1:0];      // R12
        end
    end

    // ------------------------------------------------------------------
    // Detectors
    // ------------------------------------------------------------------
    // Registered once per interval; reset reads as live voltage so release flags no loss.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            det_ff <= '{1'b0, 1'b0, 1'b1, 1'b0};
        else
        begin
            det_ff.neg_v    <= v2_mag > `PLM_V2_PICKUP_MV;        // R3
            det_ff.neg_i    <= i2_mag >= `PLM_I2_ABSENT_MA;       // R3
            det_ff.pos_v    <= v1_mag >= `PLM_V1_PICKUP_MV;       // R4
            det_ff.phase_oc <= (phase_i_a >= pickup_ff) ||         // R13
                               (phase_i_b >= pickup_ff) ||
                               (phase_i_c >= pickup_ff);
        end
    end

    // ------------------------------------------------------------------
    // Supervision decisions
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_cond  = (det_ff.neg_v && !det_ff.neg_i)                 // R1
                    || (!det_ff.pos_v && !det_ff.phase_oc);         // R2 R4
        nxt_flag  = nxt_cond;
        if (mode_ff == MODE_1 || mode_ff == MODE_3)
            nxt_flag = nxt_cond && breaker_closed_input;            // R8
        nxt_block = nxt_cond && (mode_ff == MODE_Y || mode_ff == MODE_1
                    || mode_ff == MODE_2 || mode_ff == MODE_3);     // R6 R7
        nxt_alarm = (mode_ff == MODE_2 || mode_ff == MODE_3       // R9
                     || mode_ff == MODE_4) && nxt_flag;             // R10
    end

    // Plain per-interval registers: nothing latches, so drop-out is immediate.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cond_ff  <= 1'b0;
            flag_ff  <= 1'b0;
            block_ff <= 1'b0;
            alarm_ff <= 1'b0;
        end
        else
        begin
            cond_ff  <= nxt_cond;                                  // R14
            flag_ff  <= nxt_flag;                                  // R14
            block_ff <= nxt_block;
            alarm_ff <= nxt_alarm;
        end
    end

    // ------------------------------------------------------------------
    // Logic masks
    // ------------------------------------------------------------------
    // The flag replaces one bit of the incoming relay word.
    always_comb
    begin
        relay_word                = relay_word_in;
        relay_word[`PLM_FLAG_POS] = flag_ff;                       // R11
    end

    // Masks 0..3 qualify the trip, 4..7 drive contacts, 8..9 the recloser.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hit_ff  <= '0;
            trip_ff <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `PLM_NUM_MASKS; i++)
                hit_ff[i] <= |(mask_ff[i] & relay_word);           // R12
            trip_ff <= (|(mask_ff[0] & relay_word))
                       || ((|(mask_ff[1] & relay_word)) && permissive_trip_in)
                       || ((|(mask_ff[2] & relay_word)) && !block_trip_in)
                       || ((|(mask_ff[3] & relay_word)) && breaker_open_timer_in);
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    assign irq_evt = {nxt_alarm && !alarm_ff, nxt_flag && !flag_ff, nxt_cond && !cond_ff};

    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_stat_ff <= '0;
            irq_mask_ff <= '0;
            irq_ff      <= 1'b0;
        end
        else
        begin
            if (reg_wr && reg_addr == `PLM_OFS_IRQ_STAT)
                irq_stat_ff <= (irq_stat_ff & ~reg_wdata[2:0]) | irq_evt;
            else
                irq_stat_ff <= irq_stat_ff | irq_evt;
            if (reg_wr && reg_addr == `PLM_OFS_IRQ_MASK)
                irq_mask_ff <= reg_wdata[2:0];
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Data stand for one cycle only; unmapped addresses read zero.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rdata_ff <= '0;
        else if (!reg_rd)
            rdata_ff <= '0;
        else if (reg_addr == `PLM_OFS_MODE)
            rdata_ff <= {29'h0, mode_code(mode_ff)};
        else if (reg_addr == `PLM_OFS_STATUS)
            rdata_ff <= {24'h0, det_ff, cond_ff, flag_ff, block_ff, alarm_ff};
        else if (reg_addr == `PLM_OFS_IRQ_STAT)
            rdata_ff <= {29'h0, irq_stat_ff};
        else if (reg_addr == `PLM_OFS_IRQ_MASK)
            rdata_ff <= {29'h0, irq_mask_ff};
        else if (reg_addr == `PLM_OFS_PICKUP)
            rdata_ff <= {16'h0, pickup_ff};
        else if (mask_sel)
            rdata_ff <= 32'(mask_ff[mask_idx]);
        else
            rdata_ff <= '0;
    end

    assign reg_rdata           = rdata_ff;
    assign potential_loss_flag = flag_ff;
    assign distance_block      = block_ff;
    assign directional_forward = block_ff;
    assign alarm_contact       = alarm_ff;
    assign trip_contact        = trip_ff;
    assign mask_hit            = hit_ff;
    assign irq                 = irq_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_partial_loss: assert property (@(posedge clk) disable iff (!resetn) // R1
        (v2_mag > `PLM_V2_PICKUP_MV && i2_mag < `PLM_I2_ABSENT_MA)
        ##1 !(mode_ff inside {MODE_1, MODE_3}) |=> flag_ff)
        else $error("partial loss did not raise the flag");

    a_total_loss: assert property (@(posedge clk) disable iff (!resetn) // R2
        (!det_ff.pos_v && !det_ff.phase_oc) |=> cond_ff)
        else $error("total loss term did not raise the condition");

    a_v2_thresh: assert property (@(posedge clk) disable iff (!resetn) // R3
        resetn |=> det_ff.neg_v == $past(v2_mag > 16'd14000)
                 && det_ff.neg_i == $past(i2_mag > 16'd82))
        else $error("sequence detector threshold wrong");

    a_v1_thresh: assert property (@(posedge clk) disable iff (!resetn) // R4
        resetn |=> det_ff.pos_v == $past(v1_mag > 16'd13999))
        else $error("positive sequence threshold wrong");

    a_mode_legal: assert property (@(posedge clk) disable iff (!resetn) // R5
        (reg_wr && reg_addr == `PLM_OFS_MODE && reg_wdata[2:0] > 3'h5) |=> $stable(mode_ff))
        else $error("illegal mode code was accepted");

    a_block_on: assert property (@(posedge clk) disable iff (!resetn) // R6
        (nxt_cond && mode_ff inside {MODE_Y, MODE_1, MODE_2, MODE_3})
        |=> distance_block && directional_forward)
        else $error("loss did not block distance elements");

    a_no_block: assert property (@(posedge clk) disable iff (!resetn) // R7
        (mode_ff inside {MODE_N, MODE_4}) |=> !distance_block && !directional_forward)
        else $error("distance blocked in unblocking mode");

    a_bkr_gate: assert property (@(posedge clk) disable iff (!resetn) // R8
        (mode_ff inside {MODE_1, MODE_3}) |=> flag_ff == $past(nxt_cond && breaker_closed_input))
        else $error("breaker supervision of flag wrong");

    a_alarm_mode: assert property (@(posedge clk) disable iff (!resetn) // R9
        (mode_ff inside {MODE_N, MODE_Y, MODE_1}) |=> !alarm_contact)
        else $error("alarm driven in non-alarm mode");

    a_alarm_follow: assert property (@(posedge clk) disable iff (!resetn) // R10
        (mode_ff inside {MODE_2, MODE_3, MODE_4}) |=> alarm_contact == flag_ff)
        else $error("alarm does not follow the flag");

    a_flag_mask: assert property (@(posedge clk) disable iff (!resetn) // R11
        (flag_ff && mask_ff[4][`PLM_FLAG_POS]) |=> mask_hit[4])
        else $error("flag not seen through contact mask");

    a_reclose_mask: assert property (@(posedge clk) disable iff (!resetn) // R12
        (mask_ff[9] == '0) |=> !mask_hit[9])
        else $error("empty mask produced a hit");

    a_phase_or: assert property (@(posedge clk) disable iff (!resetn) // R13
        $rose(det_ff.phase_oc) |-> $past(phase_i_a >= pickup_ff
            || phase_i_b >= pickup_ff || phase_i_c >= pickup_ff))
        else $error("phase overcurrent without any phase above pickup");

    a_drop_out: assert property (@(posedge clk) disable iff (!resetn) // R14
        !nxt_cond |=> !flag_ff && !distance_block && !alarm_contact)
        else $error("outputs held after the condition ended");

    a_irq_wins: assert property (@(posedge clk) disable iff (!resetn)
        (irq_evt[`PLM_IRQ_FLAG] && reg_wr && reg_addr == `PLM_OFS_IRQ_STAT)
        |=> irq_stat_ff[`PLM_IRQ_FLAG])
        else $error("event lost against clear");

endmodule

`default_nettype wire

// file: plm_supervision_bench.sv
/*
 Self-checking bench for the potential-loss supervision block: detector
 thresholds, the six supervision modes, interrupts and the logic masks.
 Assumes the block's register map and latencies as handed over; all
 inputs are driven just after rising edges of a single 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "plm_defs.svh"

module plm_supervision_bench
    import plm_pkg::*;
    ;
    // ------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------
    logic        clk;
    logic        resetn;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic [15:0] v2_mag;
    logic [15:0] i2_mag;
    logic [15:0] v1_mag;
    logic [15:0] phase_i_a;
    logic [15:0] phase_i_b;
    logic [15:0] phase_i_c;
    logic        breaker_closed_input;
    logic        permissive_trip_in;
    logic        block_trip_in;
    logic        breaker_open_timer_in;
    logic [23:0] relay_word_in;
    logic        potential_loss_flag;
    logic        distance_block;
    logic        directional_forward;
    logic        alarm_contact;
    logic        trip_contact;
    logic [9:0]  mask_hit;
    logic        irq;
    int          err_total;
    int          checks_done;

    plm_supervision #(.RW_W(24)) plm_supervision_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .v2_mag(v2_mag),
        .i2_mag(i2_mag), .v1_mag(v1_mag), .phase_i_a(phase_i_a), .phase_i_b(phase_i_b),
        .phase_i_c(phase_i_c), .breaker_closed_input(breaker_closed_input),
        .permissive_trip_in(permissive_trip_in), .block_trip_in(block_trip_in),
        .breaker_open_timer_in(breaker_open_timer_in), .relay_word_in(relay_word_in),
        .potential_loss_flag(potential_loss_flag), .distance_block(distance_block),
        .directional_forward(directional_forward), .alarm_contact(alarm_contact),
        .trip_contact(trip_contact), .mask_hit(mask_hit), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // The clock toggles every half period of 50 ns.
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Ends the run; reached from the main sequence or the watchdog.
    task automatic conclude();
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // A strobe is raised after one edge and dropped after the taking edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, then return to 0.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
        #1 chk(reg_rdata, 32'h0000_0000, "read data after its cycle");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask

    // The flag path settles in two edges, the masks in three; four leave margin.
    task automatic meas(input logic [15:0] v2, i2, v1, pa, pb, pc);
        @(posedge clk);
        v2_mag    <= v2;
        i2_mag    <= i2;
        v1_mag    <= v1;
        phase_i_a <= pa;
        phase_i_b <= pb;
        phase_i_c <= pc;
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic probe(input logic [15:0] v2, i2, v1, pa, pb, pc, input logic exp);
        logic [31:0] s;
        meas(v2, i2, v1, pa, pb, pc);
        chk(potential_loss_flag, exp, "flag");
        rd(`PLM_OFS_STATUS, s);
        chk(s[3], exp, "status condition");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // A zero pickup makes the phase detector pick up on any current.
    task automatic t_reset();
        chk({potential_loss_flag, distance_block, alarm_contact, irq}, 4'h0, "outputs");
        rd_chk(`PLM_OFS_MODE, 32'h0000_0000, "mode reset");
        rd_chk(`PLM_OFS_IRQ_MASK, 32'h0000_0000, "irq mask reset");
        rd_chk(`PLM_OFS_PICKUP, 32'h0000_0000, "pickup reset");
        rd_chk(`PLM_OFS_MASK_BASE, 32'h0000_0000, "mask reset");
        rd_chk(8'h48, 32'h0000_0000, "unmapped read");
        rd_chk(`PLM_OFS_STATUS, 32'h0000_0010, "status reset");
    endtask

    // Boundary values on each side of every threshold.
    task automatic t_detect();
        wr(`PLM_OFS_PICKUP, 32'h0000_03E8);
        probe(16'h36B1, 16'h0052, 16'h4E20, 16'h0000, 16'h0000, 16'h0000, 1'b1);
        probe(16'h36B0, 16'h0052, 16'h4E20, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        probe(16'h36B1, 16'h0053, 16'h4E20, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        probe(16'h0000, 16'h0000, 16'h36AF, 16'h0000, 16'h0000, 16'h0000, 1'b1);
        probe(16'h0000, 16'h0000, 16'h36B0, 16'h0000, 16'h0000, 16'h0000, 1'b0);
        probe(16'h0000, 16'h0000, 16'h36AF, 16'h03E8, 16'h0000, 16'h0000, 1'b0);
        probe(16'h0000, 16'h0000, 16'h36AF, 16'h0000, 16'h03E8, 16'h0000, 1'b0);
        probe(16'h0000, 16'h0000, 16'h36AF, 16'h0000, 16'h0000, 16'h03E7, 1'b1);
        probe(16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h03E8, 1'b0);
    endtask

    // Every mode with the breaker open and closed while a loss stands.
    task automatic t_modes();
        logic [2:0] codes [6];
        logic [5:0] blk_t;
        logic [5:0] gate_t;
        logic [5:0] alm_t;
        logic       fl;
        codes  = '{`PLM_CODE_N, `PLM_CODE_Y, `PLM_CODE_1, `PLM_CODE_2, `PLM_CODE_3, `PLM_CODE_4};
        blk_t  = 6'b011110;
        gate_t = 6'b010100;
        alm_t  = 6'b111000;
        meas(16'h3A98, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        for (int m = 0; m < 6; m++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                wr(`PLM_OFS_MODE, {29'h0, codes[m]});
                breaker_closed_input <= b[0];
                repeat (4) @(posedge clk);
                #1;
                fl = gate_t[m] ? b[0] : 1'b1;
                chk(potential_loss_flag, fl, "flag in mode");
                chk(distance_block, blk_t[m], "distance block");
                chk(directional_forward, blk_t[m], "directional forward");
                chk(alarm_contact, alm_t[m] & fl, "alarm");
                rd_chk(`PLM_OFS_MODE, {29'h0, codes[m]}, "mode readback");
            end
        end
        wr(`PLM_OFS_MODE, 32'h0000_0006);
        rd_chk(`PLM_OFS_MODE, {29'h0, `PLM_CODE_4}, "illegal mode kept");
    endtask

    // Sticky status, masking, and write-one-to-clear of single bits.
    task automatic t_irq();
        meas(16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        wr(`PLM_OFS_MODE, {29'h0, `PLM_CODE_2});
        wr(`PLM_OFS_IRQ_STAT, 32'h0000_0007);
        wr(`PLM_OFS_IRQ_MASK, 32'h0000_0007);
        rd_chk(`PLM_OFS_IRQ_STAT, 32'h0000_0000, "irq status cleared");
        meas(16'h3A98, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        chk(irq, 1'b1, "irq raised");
        wr(`PLM_OFS_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0, "irq masked");
        meas(16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        rd_chk(`PLM_OFS_IRQ_STAT, 32'h0000_0007, "irq status sticky");
        wr(`PLM_OFS_IRQ_STAT, 32'h0000_0001);
        rd_chk(`PLM_OFS_IRQ_STAT, 32'h0000_0006, "irq single clear");
        wr(`PLM_OFS_IRQ_MASK, 32'h0000_0002);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b1, "irq unmasked");
        wr(`PLM_OFS_IRQ_STAT, 32'h0000_0006);
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b0, "irq cleared");
        @(posedge clk);
        v2_mag <= 16'h3A98;
        wr(`PLM_OFS_IRQ_STAT, 32'h0000_0007);
        rd_chk(`PLM_OFS_IRQ_STAT, 32'h0000_0007, "set wins over clear");
    endtask

    // The flag as a bit of all ten masks, then the trip qualifiers.
    task automatic t_masks();
        wr(`PLM_OFS_MODE, {29'h0, `PLM_CODE_N});
        for (int i = 0; i < `PLM_NUM_MASKS; i++)
            wr(`PLM_OFS_MASK_BASE + 8'(i * 4), 32'h0001_0000);
        rd_chk(8'h60, 32'h0000_0000, "aliased mask address");
        meas(16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        chk({trip_contact, mask_hit}, 11'h000, "masks idle");
        meas(16'h3A98, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        chk({trip_contact, mask_hit}, 11'h7FF, "masks on flag");
        wr(`PLM_OFS_MASK_BASE, 32'h0000_0000);
        block_trip_in <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(trip_contact, 1'b0, "trip qualified off");
        permissive_trip_in <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(trip_contact, 1'b1, "trip permissive");
        permissive_trip_in    <= 1'b0;
        breaker_open_timer_in <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(trip_contact, 1'b1, "trip breaker open");
        wr(`PLM_OFS_MASK_BASE + 8'h14, 32'h0000_0008);
        relay_word_in <= 24'h00_0008;
        meas(16'h0000, 16'h0000, 16'h4E20, 16'h0000, 16'h0000, 16'h0000);
        chk(mask_hit, 10'h020, "contact mask on relay word");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // The watchdog only matters if a task stalls; normal runs end first.
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        conclude();
    end

    initial
    begin
        err_total = 0;
        checks_done = 0;
        resetn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {v2_mag, i2_mag, v1_mag} = 48'h0;
        {phase_i_a, phase_i_b, phase_i_c} = 48'h0;
        breaker_closed_input = 1'b0;
        permissive_trip_in = 1'b0;
        block_trip_in = 1'b0;
        breaker_open_timer_in = 1'b0;
        relay_word_in = 24'h00_0000;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_detect();
        t_modes();
        t_irq();
        t_masks();
        conclude();
    end

endmodule

`default_nettype wire
